// ==== hw/jis_pkg.sv ====
package jis_pkg;

	// ----------------------------------------------------------------
	// register widths
	// ----------------------------------------------------------------
	localparam int IR_LEN      = 10;
	localparam int SIG_LEN     = 16;
	localparam int WORD_LEN    = 32;
	localparam int ID_VER_W    = 4;
	localparam int ID_PART_W   = 16;
	localparam int ID_MFR_W    = 11;
	localparam int BSR_LEN_MIN = 96;
	localparam int BSR_LEN_MID = 288;
	localparam int BSR_LEN_MAX = 624;

	// ----------------------------------------------------------------
	// configuration store
	// ----------------------------------------------------------------
	localparam int CFG_AW    = 4;
	localparam int CFG_DW    = 16;
	localparam int CFG_LEN   = CFG_AW + CFG_DW;
	localparam int CFG_WORDS = 16;
	localparam int UCODE_LO  = 0;
	localparam int UCODE_HI  = 1;

	// ----------------------------------------------------------------
	// power-on timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ     = 40;
	localparam int POR_TIME_US = 100;
	localparam int POR_CNT_W   = 12;
	localparam logic [POR_CNT_W-1:0] POR_CYCLES = POR_CNT_W'(POR_TIME_US * CLK_MHZ);

	// ----------------------------------------------------------------
	// instruction codes and capture value
	// ----------------------------------------------------------------
	localparam logic [IR_LEN-1:0] IR_CAPT     = 10'h001;
	localparam logic [IR_LEN-1:0] OP_EXTEST   = 10'h000;
	localparam logic [IR_LEN-1:0] OP_SAMPLE   = 10'h005;
	localparam logic [IR_LEN-1:0] OP_IDENTIFICATION_WORD   = 10'h006;
	localparam logic [IR_LEN-1:0] OP_USER_CODE_WORD = 10'h007;
	localparam logic [IR_LEN-1:0] OP_SIG      = 10'h010;
	localparam logic [IR_LEN-1:0] OP_CFG_PROG = 10'h020;
	localparam logic [IR_LEN-1:0] OP_CFG_READ = 10'h021;
	localparam logic [IR_LEN-1:0] OP_SEC_SET  = 10'h030;
	localparam logic [IR_LEN-1:0] OP_ERASE    = 10'h040;
	localparam logic [IR_LEN-1:0] OP_BYPASS   = 10'h3ff;

	// ----------------------------------------------------------------
	// test access port states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
		TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7,
		TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR  = 4'hb,
		TAP_EX1_IR = 4'hc, TAP_PA_IR  = 4'hd, TAP_EX2_IR = 4'he, TAP_UPD_IR = 4'hf
	} jis_tap_e;

	// next tap state from the mode select line
	function automatic jis_tap_e jis_tap_next(input jis_tap_e s, input logic tms);
		case (s)
			TAP_RESET:  return tms ? TAP_RESET  : TAP_IDLE;
			TAP_IDLE:   return tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: return tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: return tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  return tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: return tms ? TAP_UPD_DR : TAP_PA_DR;
			TAP_PA_DR:  return tms ? TAP_EX2_DR : TAP_PA_DR;
			TAP_EX2_DR: return tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: return tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: return tms ? TAP_RESET  : TAP_CAP_IR;
			TAP_CAP_IR: return tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  return tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: return tms ? TAP_UPD_IR : TAP_PA_IR;
			TAP_PA_IR:  return tms ? TAP_EX2_IR : TAP_PA_IR;
			TAP_EX2_IR: return tms ? TAP_UPD_IR : TAP_SH_IR;
			default:    return tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
	endfunction : jis_tap_next

endpackage : jis_pkg

// ==== hw/jis_tap_ctrl.sv ====
`timescale 1ns/1ps
module jis_tap_ctrl import jis_pkg::*; (
	input wire logic tck,              // test clock
	input wire logic rst_n,            // async reset, active low
	input wire logic tms,              // mode select
	jis_tap_if.ctl   tap               // state to the register logic
);

	typedef struct packed {
		jis_tap_e st;
	} jis_ctl_s;

	jis_ctl_s cur;
	jis_ctl_s next_cur;

	// state walk on each rising test clock edge
	always_comb begin
		next_cur    = cur;
		next_cur.st = jis_tap_next(cur.st, tms);
	end

	// state register
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '{st: TAP_RESET};
		end else begin
			cur <= next_cur;
		end
	end

	assign tap.st = cur.st;

endmodule : jis_tap_ctrl

// ==== hw/jis_tap_if.sv ====
`timescale 1ns/1ps
interface jis_tap_if;
	import jis_pkg::*;
	jis_tap_e st;                      // current tap state
	modport ctl (output st);
	modport dev (input st);
endinterface : jis_tap_if

// ==== hw/jis_top.sv ====
`timescale 1ns/1ps
module jis_top import jis_pkg::*; #(
	parameter int                    BSR_LEN    = BSR_LEN_MIN, // boundary cells
	parameter bit                    ENHANCED   = 1'b1,        // hot-socket variant
	parameter logic [ID_VER_W-1:0]   ID_VERSION = 4'h2,        // arbitrary value
	parameter logic [ID_PART_W-1:0]  ID_PART    = 16'h5a3c,    // arbitrary value
	parameter logic [ID_MFR_W-1:0]   ID_MFR     = 11'h2a5      // arbitrary value
) (
	input  wire logic               clk,         // core clock, 40 MHz
	input  wire logic               rst_n,       // async reset, active low
	input  wire logic               tck,         // test clock
	input  wire logic               tms,         // test mode select
	input  wire logic               tdi,         // test data in
	output logic                    tdo,         // test data out
	output logic                    tdo_oe,      // tdo driven
	input  wire logic               user_oe_req, // user logic wants pins driven
	output logic                    pin_oe,      // user pins driven
	input  wire logic [BSR_LEN-1:0] bsr_pin,     // pin levels seen by boundary cells
	output logic      [BSR_LEN-1:0] bsr_out,     // boundary drive values
	output logic                    bsr_drive    // boundary cells own the pins
);

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [IR_LEN-1:0]  ir;
		logic [IR_LEN-1:0]  ir_sh;
		logic [BSR_LEN-1:0] dr_sh;
		logic [SIG_LEN-1:0] sig;
		logic [CFG_AW-1:0]  addr;
		logic               erasing;
		logic               id_s1;
		logic               id_s2;
		logic [BSR_LEN-1:0] pin_s1;
		logic [BSR_LEN-1:0] pin_s2;
		logic [BSR_LEN-1:0] bsr_upd;
		logic               bsr_drive;
		logic               tdo;
		logic               tdo_oe;
	} jis_jtag_s;

	typedef struct packed {
		logic [CFG_WORDS-1:0][CFG_DW-1:0] mem;
		logic                              secure;
	} jis_nv_s;

	typedef struct packed {
		logic [POR_CNT_W-1:0] por_cnt;
		logic                 init_done;
		logic                 er_s1;
		logic                 er_s2;
		logic                 pin_oe;
	} jis_core_s;

	jis_tap_if tap ();

	jis_jtag_s j;
	jis_jtag_s next_j;
	jis_nv_s   v = '0;                 // nonvolatile, untouched by rst_n
	jis_nv_s   next_v;
	jis_core_s c;
	jis_core_s next_c;
	jis_tap_e  s;

	assign s = tap.st;

	// ----------------------------------------------------------------
	// tap controller
	// ----------------------------------------------------------------
	jis_tap_ctrl u_tap (
		.tck   (tck),
		.rst_n (rst_n),
		.tms   (tms),
		.tap   (tap)
	);

	// ----------------------------------------------------------------
	// test clock domain
	// ----------------------------------------------------------------
	// capture, shift and update of the selected register
	always_comb begin
		int       dlen;
		jis_tap_e ns;
		dlen   = 1;
		ns     = jis_tap_next(s, tms);
		next_j = j;
		next_v = v;

		// init status and pin levels from outside this domain
		next_j.id_s1   = c.init_done;
		next_j.id_s2   = j.id_s1;
		next_j.pin_s1  = bsr_pin;
		next_j.pin_s2  = j.pin_s1;
		next_j.erasing = (s == TAP_IDLE) && (j.ir == OP_ERASE);

		// data register length by instruction
		case (j.ir)
			OP_IDENTIFICATION_WORD, OP_USER_CODE_WORD: dlen = WORD_LEN;
			OP_SIG:                 dlen = SIG_LEN;
			OP_CFG_PROG,
			OP_CFG_READ:            dlen = CFG_LEN;
			OP_SAMPLE, OP_EXTEST:   dlen = BSR_LEN;
			default:                dlen = 1;
		endcase

		case (s)
			TAP_RESET: begin
				next_j.ir        = OP_IDENTIFICATION_WORD;
				next_j.bsr_drive = 1'b0;
			end
			TAP_CAP_IR: next_j.ir_sh = IR_CAPT;
			TAP_SH_IR:  next_j.ir_sh = {tdi, j.ir_sh[IR_LEN-1:1]};
			TAP_UPD_IR: begin
				// instructions are refused until initialisation ends
				next_j.ir        = j.id_s2 ? j.ir_sh : OP_BYPASS;
				next_j.bsr_drive = j.id_s2 && (j.ir_sh == OP_EXTEST);
			end
			TAP_CAP_DR: begin
				next_j.dr_sh = '0;
				case (j.ir)
					OP_IDENTIFICATION_WORD: next_j.dr_sh[WORD_LEN-1:0] =
						{ID_VERSION, ID_PART, ID_MFR, 1'b1};
					OP_USER_CODE_WORD: next_j.dr_sh[WORD_LEN-1:0] =
						{v.mem[UCODE_HI], v.mem[UCODE_LO]};
					OP_SIG: next_j.dr_sh[SIG_LEN-1:0] = j.sig;
					OP_CFG_READ: next_j.dr_sh[CFG_LEN-1:0] =
						{j.addr, v.secure ? CFG_DW'(0) : v.mem[j.addr]};
					OP_CFG_PROG: next_j.dr_sh[CFG_LEN-1:0] = {j.addr, CFG_DW'(0)};
					OP_SAMPLE, OP_EXTEST: next_j.dr_sh = j.pin_s2;
					default: next_j.dr_sh = '0;
				endcase
			end
			TAP_SH_DR: begin
				next_j.dr_sh         = j.dr_sh >> 1;
				next_j.dr_sh[dlen-1] = tdi;
			end
			TAP_UPD_DR: begin
				case (j.ir)
					OP_SIG: next_j.sig = j.dr_sh[SIG_LEN-1:0];
					OP_CFG_PROG: begin
						next_j.addr = j.dr_sh[CFG_LEN-1:CFG_DW];
						next_v.mem[j.dr_sh[CFG_LEN-1:CFG_DW]] = j.dr_sh[CFG_DW-1:0];
					end
					OP_CFG_READ: next_j.addr = j.dr_sh[CFG_LEN-1:CFG_DW];
					OP_SAMPLE, OP_EXTEST: next_j.bsr_upd = j.dr_sh;
					default: ;
				endcase
			end
			TAP_IDLE: begin
				case (j.ir)
					OP_SEC_SET: next_v.secure = 1'b1;
					OP_ERASE:   next_v = '0;
					default: ;
				endcase
			end
			default: ;
		endcase

		// tdo shows bit zero of the register being shifted
		next_j.tdo    = (ns == TAP_SH_IR) ? next_j.ir_sh[0] : next_j.dr_sh[0];
		next_j.tdo_oe = (ns == TAP_SH_IR) || (ns == TAP_SH_DR);
	end

	// test clock registers
	always_ff @(posedge tck or negedge rst_n) begin
		if (!rst_n) begin
			j <= '{ir: OP_IDENTIFICATION_WORD, default: '0};
		end else begin
			j <= next_j;
		end
	end

	// nonvolatile store, changed only by programming commands
	always_ff @(posedge tck) begin
		v <= next_v;
	end

	// ----------------------------------------------------------------
	// core clock domain
	// ----------------------------------------------------------------
	// power-on count and user output gating
	always_comb begin
		next_c       = c;
		next_c.er_s1 = j.erasing;
		next_c.er_s2 = c.er_s1;
		if (!c.init_done) begin
			if (c.por_cnt == POR_CYCLES - POR_CNT_W'(1)) begin
				next_c.init_done = 1'b1;
			end else begin
				next_c.por_cnt = c.por_cnt + POR_CNT_W'(1);
			end
		end
		// enhanced parts stay quiet until ready and while erasing
		if (ENHANCED) begin
			next_c.pin_oe = c.init_done && !c.er_s2 && user_oe_req;
		end else begin
			next_c.pin_oe = user_oe_req;
		end
	end

	// core clock registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c <= '0;
		end else begin
			c <= next_c;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign tdo       = j.tdo;
	assign tdo_oe    = j.tdo_oe;
	assign bsr_out   = j.bsr_upd;
	assign bsr_drive = j.bsr_drive;
	assign pin_oe    = c.pin_oe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// configuration read while secure is set
	sequence seq_secure_read;
		(s == TAP_CAP_DR) && (j.ir == OP_CFG_READ) && v.secure;
	endsequence

	sequence seq_erase_step;
		(s == TAP_IDLE) && (j.ir == OP_ERASE);
	endsequence

	AST_IR_CAPT: assert property (
		@(posedge tck) disable iff (!rst_n)
		(s == TAP_CAP_IR) ##1 (s == TAP_SH_IR) |-> tdo_oe && tdo == IR_CAPT[0]
	) else $error("capture value of instruction register not on tdo");

	AST_SIG_WRITE: assert property (
		@(posedge tck) disable iff (!rst_n)
		(s == TAP_UPD_DR) && (j.ir == OP_SIG) |=> j.sig == $past(j.dr_sh[SIG_LEN-1:0])
	) else $error("signature not loaded from shifted data");

	AST_UCODE: assert property (
		@(posedge tck) disable iff (!rst_n)
		(s == TAP_CAP_DR) && (j.ir == OP_USER_CODE_WORD)
		|=> j.dr_sh[WORD_LEN-1:0] == {$past(v.mem[UCODE_HI]), $past(v.mem[UCODE_LO])}
	) else $error("user code word capture wrong");

	AST_BSR_LEN: assert property (
		@(posedge tck) disable iff (!rst_n)
		(s == TAP_SH_DR) && (j.ir == OP_SAMPLE) |=> j.dr_sh[BSR_LEN-1] == $past(tdi)
	) else $error("boundary chain length wrong");

	AST_IDENTIFICATION_WORD: assert property (
		@(posedge tck) disable iff (!rst_n)
		(s == TAP_CAP_DR) && (j.ir == OP_IDENTIFICATION_WORD)
		|=> j.dr_sh[WORD_LEN-1:0] == {ID_VERSION, ID_PART, ID_MFR, 1'b1}
	) else $error("identification word layout wrong");

	AST_SECURE_READ: assert property (
		@(posedge tck) disable iff (!rst_n)
		seq_secure_read |=> j.dr_sh[CFG_DW-1:0] == '0
	) else $error("secured data visible on readback");

	AST_SECURE_HOLD: assert property (
		@(posedge tck) disable iff (!rst_n)
		$fell(v.secure) |-> j.erasing
	) else $error("security cleared outside erase");

	AST_ERASE_ALL: assert property (
		@(posedge tck) disable iff (!rst_n)
		seq_erase_step |=> !v.secure && v.mem == '0
	) else $error("erase left data behind");

	AST_QUIET: assert property (
		@(posedge clk) disable iff (!rst_n)
		!c.init_done |-> (!pin_oe || !ENHANCED)
	) else $error("user pins driven before initialisation");

	AST_POR: assert property (
		@(posedge clk) disable iff (!rst_n)
		(c.por_cnt == POR_CYCLES - POR_CNT_W'(1)) && !c.init_done |=> c.init_done
	) else $error("initialisation not done in time");

endmodule : jis_top

// ==== testbench/jis_ctl_model.sv ====
`timescale 1ns/1ps
module jis_ctl_model import jis_pkg::*; (
	output logic		tck,	// test clock, still between frames
	output logic		tms,	// mode select
	output logic		tdi,	// data to the device
	input  wire logic	tdo	// data from the device
);
	// --------------------------------
	// test clock cycle
	// --------------------------------
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// one 15 ns period; shift time is cycles times period
	task automatic tick(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#7.5;
		q = tdo;
		tck = 1'b1;
		#7.5;
		tck = 1'b0;
	endtask : tick

	// --------------------------------
	// walks and scans
	// --------------------------------
	// idle ticks; tdi toggles so a stale level never looks valid
	task automatic idle(input int n);
		logic q;
		for (int i = 0; i < n; i++) tick(1'b0, ~tdi, q);
	endtask : idle

	// from any state to run-test/idle
	task automatic go_idle();
		logic q;
		for (int i = 0; i < 5; i++) tick(1'b1, ~tdi, q);
		tick(1'b0, ~tdi, q);
	endtask : go_idle

	// capture, shift n bits lsb first, update, back to idle
	task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout);
		logic q;
		dout = '0;
		tick(1'b0, ~tdi, q);
		tick(1'b0, ~tdi, q);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, ~tdi, q);
		tick(1'b0, ~tdi, q);
	endtask : shift

	task automatic ir_scan(input logic [IR_LEN-1:0] op, output logic [IR_LEN-1:0] cap);
		logic q;
		logic [127:0] r;
		tick(1'b1, ~tdi, q);
		tick(1'b1, ~tdi, q);
		shift(IR_LEN, 128'(op), r); // exactly ten bits
		cap = r[IR_LEN-1:0];
	endtask : ir_scan

	// caller gives the length, which may run past the selected register
	task automatic dr_scan(input int n, input logic [127:0] din, output logic [127:0] dout);
		logic q;
		tick(1'b1, ~tdi, q);
		shift(n, din, dout);
	endtask : dr_scan
endmodule : jis_ctl_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import jis_pkg::*; ;
	// --------------------------------
	// setup
	// --------------------------------
	localparam int			BSR = BSR_LEN_MIN;
	localparam logic [ID_VER_W-1:0]	VER = 4'h3;	// arbitrary value
	localparam logic [ID_PART_W-1:0]	PART = 16'hc3a5;	// arbitrary value
	localparam logic [ID_MFR_W-1:0]	MFR = 11'h155;	// arbitrary value
	localparam logic [127:0]	IDW = 128'({VER, PART, MFR, 1'b1}); // msb first
	localparam logic [BSR-1:0]	PINS = 96'h0f1e2d3c_a5a55a5a_3c2d1e0f;
	localparam logic [BSR-1:0]	NPINS = 96'hf0e1d2c3_5a5aa5a5_c3d2e1f0;	// inverse of PINS
	localparam logic [127:0]	M32 = 128'hffff_ffff;
	localparam logic [127:0]	M20 = 128'hf_ffff;

	typedef struct {
		logic [IR_LEN-1:0]	op;
		int			len;
		logic [127:0]		din;
		logic [127:0]		exp;
		logic [127:0]		mask;
	} jis_row_s;

	logic			clk, rst_n, tck, tms, tdi, tdo, tdo_oe;
	logic			user_oe_req, pin_oe, bsr_drive;
	logic [BSR-1:0]		bsr_pin, bsr_out;
	logic [IR_LEN-1:0]	cap;
	logic [127:0]		dout;
	int			err_count = 0;
	int			checks_done = 0;
	int			since_rel;
	jis_row_s		rows [12];

	jis_top #(.BSR_LEN(BSR), .ENHANCED(1'b1), .ID_VERSION(VER), .ID_PART(PART),
		.ID_MFR(MFR)) DUT (
		.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .user_oe_req(user_oe_req), .pin_oe(pin_oe),
		.bsr_pin(bsr_pin), .bsr_out(bsr_out), .bsr_drive(bsr_drive));
	jis_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	// core clock, 25 ns
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// core cycles since reset release
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) since_rel <= 0;
		else since_rel <= since_rel + 1;
	end

	// --------------------------------
	// compare and report
	// --------------------------------
	task automatic chk_vec(input logic [127:0] got, input logic [127:0] exp, input string s);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask : chk_vec

	task automatic chk_bit(input logic got, input logic exp, input string s);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %b", $time, s, got);
		end
	endtask : chk_bit

	task automatic results();
		$display("mismatches %0d comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	// --------------------------------
	// sequences
	// --------------------------------
	task automatic do_reset();
		@(negedge clk);
		rst_n = 1'b0;
		u_ctl.idle(2);
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		chk_bit(tdo_oe, 1'b0, "tdo enable after reset");
		chk_bit(pin_oe, 1'b0, "pins after reset");
		u_ctl.go_idle();
	endtask : do_reset

	// bounded wait for the pins to be handed over
	task automatic wait_init();
		for (int n = 0; n < 4200 && pin_oe !== 1'b1; n++) @(negedge clk);
		chk_bit(since_rel >= 3998 && since_rel <= 4004, 1'b1, "power-on time");
		if (pin_oe !== 1'b1) results();
		u_ctl.idle(4);
	endtask : wait_init

	task automatic scan(input jis_row_s r);
		u_ctl.ir_scan(r.op, cap);
		chk_vec(128'(cap), 128'(IR_CAPT), "instruction capture");
		u_ctl.dr_scan(r.len, r.din, dout);
		chk_vec(dout & r.mask, r.exp, "data scan");
	endtask : scan

	// select address 5, then read it back
	task automatic read_cfg(input logic [15:0] d);
		scan(jis_row_s'{OP_CFG_READ, CFG_LEN, 128'h5_0000, 128'(d), 128'h0_ffff});
		scan(jis_row_s'{OP_CFG_READ, CFG_LEN, 128'h5_0000, 128'({4'h5, d}), M20});
	endtask : read_cfg

	initial begin
		rst_n = 1'b0;
		user_oe_req = 1'b1;
		bsr_pin = PINS;
		rows[0] = '{OP_IDENTIFICATION_WORD, 32, '0, IDW, M32};
		rows[1] = '{OP_SIG, SIG_LEN, 128'hbeef, '0, 128'hffff};
		rows[2] = '{OP_SIG, SIG_LEN, 128'h1234, 128'hbeef, 128'hffff};
		rows[3] = '{OP_CFG_PROG, CFG_LEN, 128'h0_1111, '0, '0};
		rows[4] = '{OP_CFG_PROG, CFG_LEN, 128'h1_2222, '0, '0};
		rows[5] = '{OP_CFG_PROG, CFG_LEN, 128'h5_5a5a, '0, '0};
		rows[6] = '{OP_USER_CODE_WORD, 32, '0, 128'h2222_1111, M32};
		rows[7] = '{OP_CFG_READ, CFG_LEN, 128'h5_0000, 128'h5_5a5a, M20};
		rows[8] = '{OP_CFG_READ, CFG_LEN, 128'h5_0000, 128'h5_5a5a, M20};
		rows[9] = '{OP_SAMPLE, BSR + 1, 128'h1, {31'h0, 1'b1, PINS}, {32'h1, {BSR{1'b1}}}};
		rows[10] = '{OP_BYPASS, 2, 128'h1, 128'h2, 128'h3};
		rows[11] = '{OP_EXTEST, BSR, 128'(NPINS), 128'(PINS), 128'({BSR{1'b1}})};
		do_reset();
		// identification word straight after reset, then refusal before init
		u_ctl.dr_scan(32, '0, dout);
		chk_vec(dout & M32, IDW, "word after reset");
		u_ctl.ir_scan(OP_SIG, cap);
		chk_vec(128'(cap), 128'(IR_CAPT), "early capture");
		u_ctl.dr_scan(17, 128'h1_beef, dout);
		chk_vec(dout & 128'h1_ffff, 128'h1_7dde, "bypass before init");
		wait_init();
		foreach (rows[i]) scan(rows[i]);
		// last row loaded the boundary latch under the drive instruction
		chk_vec(128'(bsr_out), 128'(NPINS), "boundary update");
		chk_bit(bsr_drive, 1'b1, "boundary drive");
		// pins follow the user request once running
		@(negedge clk);
		user_oe_req = 1'b0;
		repeat (2) @(negedge clk);
		chk_bit(pin_oe, 1'b0, "pins released");
		user_oe_req = 1'b1;
		repeat (2) @(negedge clk);
		chk_bit(pin_oe, 1'b1, "pins driven");
		// secured part hides configuration, user code stays readable
		scan(jis_row_s'{OP_SEC_SET, 1, '0, '0, '0});
		u_ctl.idle(3);
		chk_bit(bsr_drive, 1'b0, "boundary released");
		read_cfg(16'h0000);
		scan(jis_row_s'{OP_USER_CODE_WORD, 32, '0, 128'h2222_1111, M32});
		// reset leaves security in place
		do_reset();
		wait_init();
		read_cfg(16'h0000);
		// full erase clears security and data
		scan(jis_row_s'{OP_ERASE, 1, '0, '0, '0});
		u_ctl.idle(3);
		scan(jis_row_s'{OP_USER_CODE_WORD, 32, '0, '0, M32});
		scan(jis_row_s'{OP_CFG_PROG, CFG_LEN, 128'h5_5a5a, '0, '0});
		read_cfg(16'h5a5a);
		results();
	end
endmodule : tb_top
